// file: rtl/twdfp_map.vh
`ifndef TWDFP_MAP_VH
`define TWDFP_MAP_VH

// Data register targets selected by target_r
`define TWDFP_ADDR_PART_ID 8'h00
`define TWDFP_ADDR_SIL_REV 8'h01
`define TWDFP_ADDR_FP_CTL 8'h02
`define TWDFP_ADDR_FP_DATA 8'hB4

// Reset values
`define TWDFP_RST_TARGET 8'h00
`define TWDFP_RST_FP_CTL 8'h00
`define TWDFP_RST_FP_DATA 8'h00

// Read value for an unmapped target
`define TWDFP_UNMAPPED_VAL 8'h00

// Unlock codes, in order
`define TWDFP_UNLOCK_FIRST 8'h02
`define TWDFP_UNLOCK_SECOND 8'h01

// Flash command codes
`define TWDFP_CMD_BLK_READ 8'h06
`define TWDFP_CMD_BLK_WRITE 8'h07
`define TWDFP_CMD_PAGE_ERASE 8'h08
`define TWDFP_CMD_DEV_ERASE 8'h03

// Instruction field: bit 0 write, bit 1 address access
`define TWDFP_INS_WRITE_BIT 0
`define TWDFP_INS_ADDR_BIT 1

// Index of the last bit in each link frame field
`define TWDFP_INS_BITS 3'h1
`define TWDFP_DATA_LAST 3'h7

`endif

// file: rtl/twdfp_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module twdfp_pin_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rstn,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_r
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;
  integer i;

  // Level moves only once stages two and three agree
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
      level_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_r[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/twdfp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "twdfp_map.vh"

module twdfp_port #(
  parameter [7:0] PART_ID = 8'h5A, // Arbitrary value
  parameter [7:0] SIL_REV = 8'h11 // Arbitrary value
) (
  input wire clk,
  input wire rstn,
  input wire link_clock_pin,
  input wire link_data_pin_in,
  output reg link_data_pin_out,
  output reg link_data_pin_oe,
  input wire core_halted,
  output reg pins_borrowed_r,
  output reg prog_enabled_r,
  output reg [7:0] fp_byte_r,
  output reg fp_byte_valid_r,
  output reg fp_byte_is_cmd_r,
  output reg cmd_blk_read_r,
  output reg cmd_blk_write_r,
  output reg cmd_page_erase_r,
  output reg cmd_dev_erase_r,
  input wire [7:0] flash_rd_data,
  input wire flash_rd_valid,
  input wire flash_cmd_done
);

  localparam ST_IDLE = 3'h0;
  localparam ST_INS = 3'h1;
  localparam ST_WDAT = 3'h2;
  localparam ST_ACK = 3'h3;
  localparam ST_TURN = 3'h4;
  localparam ST_RDAT = 3'h5;

  wire [1:0] pin_level;
  reg clk_prev_r;
  reg [2:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [1:0] ins_r;
  reg [7:0] shift_r;
  reg [7:0] target_r;
  reg [7:0] fp_ctl_r;
  reg [7:0] fp_data_r;
  reg unlock_armed_r;
  reg in_cmd_r;
  wire link_clk_lvl;
  wire link_dat_lvl;
  wire rise;
  wire [1:0] ins_full;
  wire [7:0] wbyte;
  wire commit;
  wire wr_target;
  wire wr_ctl;
  wire wr_data;

  // Link clock is sampled, not used as a clock
  twdfp_pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in({link_data_pin_in, link_clock_pin}),
    .level_r(pin_level)
  );

  assign link_clk_lvl = pin_level[0];
  assign link_dat_lvl = pin_level[1];
  assign rise = link_clk_lvl & ~clk_prev_r & core_halted;
  assign ins_full = {link_dat_lvl, ins_r[1]};
  assign wbyte = {link_dat_lvl, shift_r[7:1]};
  assign commit = rise && (state_r == ST_WDAT) && (bit_cnt_r == `TWDFP_DATA_LAST);
  assign wr_target = commit && ins_r[`TWDFP_INS_ADDR_BIT];
  assign wr_ctl = commit && !ins_r[`TWDFP_INS_ADDR_BIT] && (target_r == `TWDFP_ADDR_FP_CTL);
  assign wr_data = commit && !ins_r[`TWDFP_INS_ADDR_BIT] && (target_r == `TWDFP_ADDR_FP_DATA);

  // Read mux; one function serves address and data reads
  function [7:0] read_value;
    input addr_access;
    input [7:0] tgt;
    input [7:0] ctl;
    input [7:0] dat;
    begin
      if (addr_access) begin
        read_value = tgt;
      end else begin
        case (tgt)
          `TWDFP_ADDR_PART_ID: read_value = PART_ID;
          `TWDFP_ADDR_SIL_REV: read_value = SIL_REV;
          `TWDFP_ADDR_FP_CTL: read_value = ctl;
          `TWDFP_ADDR_FP_DATA: read_value = dat;
          default: read_value = `TWDFP_UNMAPPED_VAL;
        endcase
      end
    end
  endfunction

  // Frame engine: start bit, 2 instruction bits, then data or turnaround
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_prev_r <= 1'b0;
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      ins_r <= 2'h0;
      shift_r <= 8'h00;
      link_data_pin_out <= 1'b0;
      link_data_pin_oe <= 1'b0;
      pins_borrowed_r <= 1'b0;
    end else begin
      clk_prev_r <= link_clk_lvl;
      pins_borrowed_r <= core_halted;
      if (!core_halted) begin
        // Abandon any frame; never drive a pin the user owns
        state_r <= ST_IDLE;
        link_data_pin_oe <= 1'b0;
      end else if (rise) begin
        case (state_r)
          ST_IDLE: begin
            if (link_dat_lvl) begin
              state_r <= ST_INS;
              bit_cnt_r <= 3'h0;
            end
          end
          ST_INS: begin
            ins_r <= ins_full;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == `TWDFP_INS_BITS) begin
              bit_cnt_r <= 3'h0;
              if (ins_full[`TWDFP_INS_WRITE_BIT]) begin
                state_r <= ST_WDAT;
              end else begin
                state_r <= ST_TURN;
                shift_r <= read_value(ins_full[`TWDFP_INS_ADDR_BIT], target_r, fp_ctl_r, fp_data_r);
              end
            end
          end
          ST_WDAT: begin
            shift_r <= wbyte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == `TWDFP_DATA_LAST) begin
              state_r <= ST_ACK;
              link_data_pin_out <= 1'b1;
              link_data_pin_oe <= 1'b1;
            end
          end
          ST_ACK: begin
            link_data_pin_oe <= 1'b0;
            state_r <= ST_IDLE;
          end
          ST_TURN: begin
            link_data_pin_out <= shift_r[0];
            link_data_pin_oe <= 1'b1;
            shift_r <= {1'b0, shift_r[7:1]};
            bit_cnt_r <= 3'h0;
            state_r <= ST_RDAT;
          end
          ST_RDAT: begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == `TWDFP_DATA_LAST) begin
              link_data_pin_oe <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              link_data_pin_out <= shift_r[0];
              shift_r <= {1'b0, shift_r[7:1]};
            end
          end
          default: begin
            state_r <= ST_IDLE;
            link_data_pin_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Registers, unlock sequence and flash byte stream
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      target_r <= `TWDFP_RST_TARGET;
      fp_ctl_r <= `TWDFP_RST_FP_CTL;
      fp_data_r <= `TWDFP_RST_FP_DATA;
      unlock_armed_r <= 1'b0;
      prog_enabled_r <= 1'b0;
      in_cmd_r <= 1'b1;
      fp_byte_r <= 8'h00;
      fp_byte_valid_r <= 1'b0;
      fp_byte_is_cmd_r <= 1'b0;
      cmd_blk_read_r <= 1'b0;
      cmd_blk_write_r <= 1'b0;
      cmd_page_erase_r <= 1'b0;
      cmd_dev_erase_r <= 1'b0;
    end else begin
      fp_byte_valid_r <= 1'b0;
      fp_byte_is_cmd_r <= 1'b0;
      cmd_blk_read_r <= 1'b0;
      cmd_blk_write_r <= 1'b0;
      cmd_page_erase_r <= 1'b0;
      cmd_dev_erase_r <= 1'b0;
      if (wr_target) begin
        target_r <= wbyte;
      end
      if (wr_ctl) begin
        fp_ctl_r <= wbyte;
        // Any other fp_ctl_r write between the two codes restarts the sequence
        unlock_armed_r <= (wbyte == `TWDFP_UNLOCK_FIRST);
        if (unlock_armed_r && (wbyte == `TWDFP_UNLOCK_SECOND)) begin
          prog_enabled_r <= 1'b1;
        end
      end
      if (flash_rd_valid) begin
        fp_data_r <= flash_rd_data;
      end
      if (flash_cmd_done) begin
        in_cmd_r <= 1'b1;
      end
      // Bytes before unlock are stored but not forwarded to flash
      if (wr_data) begin
        fp_data_r <= wbyte;
        if (prog_enabled_r) begin
          fp_byte_r <= wbyte;
          fp_byte_valid_r <= 1'b1;
          fp_byte_is_cmd_r <= in_cmd_r;
          if (in_cmd_r) begin
            case (wbyte)
              `TWDFP_CMD_BLK_READ: begin
                cmd_blk_read_r <= 1'b1;
                in_cmd_r <= 1'b0;
              end
              `TWDFP_CMD_BLK_WRITE: begin
                cmd_blk_write_r <= 1'b1;
                in_cmd_r <= 1'b0;
              end
              `TWDFP_CMD_PAGE_ERASE: begin
                cmd_page_erase_r <= 1'b1;
                in_cmd_r <= 1'b0;
              end
              `TWDFP_CMD_DEV_ERASE: begin
                cmd_dev_erase_r <= 1'b1;
                in_cmd_r <= 1'b0;
              end
              default: in_cmd_r <= 1'b1;
            endcase
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/twdfp_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module twdfp_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic core_halted,
  input wire logic link_data_pin_oe,
  input wire logic prog_enabled_r,
  input wire logic [7:0] fp_byte_r,
  input wire logic fp_byte_valid_r,
  input wire logic fp_byte_is_cmd_r,
  input wire logic cmd_blk_read_r,
  input wire logic cmd_blk_write_r,
  input wire logic cmd_page_erase_r,
  input wire logic cmd_dev_erase_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_cmd(c);
    fp_byte_valid_r && fp_byte_is_cmd_r && fp_byte_r == c;
  endsequence
  sequence s_any;
    cmd_blk_read_r || cmd_blk_write_r || cmd_page_erase_r || cmd_dev_erase_r;
  endsequence
  property p_rd; s_cmd(8'h06) |-> cmd_blk_read_r; endproperty
  property p_wr; s_cmd(8'h07) |-> cmd_blk_write_r; endproperty
  property p_pe; s_cmd(8'h08) |-> cmd_page_erase_r; endproperty
  property p_de; s_cmd(8'h03) |-> cmd_dev_erase_r; endproperty
  property p_any; s_any |-> fp_byte_valid_r && fp_byte_is_cmd_r; endproperty
  property p_fwd; fp_byte_valid_r |-> prog_enabled_r; endproperty
  property p_stk; prog_enabled_r |=> prog_enabled_r [*3]; endproperty
  property p_pls; fp_byte_valid_r |=> !fp_byte_valid_r; endproperty
  property p_brw; !core_halted ##1 !core_halted |-> !link_data_pin_oe; endproperty
  a_rd: assert property (p_rd) else $error("block read missed");
  a_wr: assert property (p_wr) else $error("block write missed");
  a_pe: assert property (p_pe) else $error("page erase missed");
  a_de: assert property (p_de) else $error("device erase missed");
  a_any: assert property (p_any) else $error("stray command pulse");
  a_fwd: assert property (p_fwd) else $error("byte passed while locked");
  a_stk: assert property (p_stk) else $error("programming dropped");
  a_pls: assert property (p_pls) else $error("byte pulse too long");
  a_brw: assert property (p_brw) else $error("pin driven while running");
endmodule
`default_nettype wire

// file: tb/twdfp_host.sv
`timescale 1ns/1ps
`default_nettype none
module twdfp_host (
  input wire logic clk,
  input wire logic dw,
  output logic ck,
  output logic hd,
  output logic hoe
);
  initial begin
    ck = 0;
    hd = 0;
    hoe = 1;
  end
  // Clock stands low between frames; data moves mid-low
  task pulse(input logic b, output logic s);
    repeat (2) @(negedge clk);
    hd = b;
    repeat (2) @(negedge clk);
    s = dw;
    ck = 1;
    repeat (4) @(negedge clk);
    ck = 0;
  endtask
  task xfer(input logic w, input logic a, input logic [7:0] v, output logic [7:0] r);
    logic s;
    r = 8'h00;
    pulse(1'b1, s);
    pulse(w, s);
    pulse(a, s);
    hoe = w;
    if (w) begin
      for (int i = 0; i < 8; i++) pulse(v[i], s);
      hoe = 0;
    end
    pulse(1'b0, r[0]);
    if (!w) begin
      for (int i = 0; i < 8; i++) pulse(1'b0, r[i]);
    end
    hoe = 1;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rstn, core_halted, flash_rd_valid, flash_cmd_done;
  logic [7:0] flash_rd_data, fp_byte_r, r;
  wire link_clock_pin, hd, hoe, link_data_pin_in;
  logic link_data_pin_out, link_data_pin_oe, pins_borrowed_r, prog_enabled_r;
  logic fp_byte_valid_r, fp_byte_is_cmd_r;
  logic cmd_blk_read_r, cmd_blk_write_r, cmd_page_erase_r, cmd_dev_erase_r;
  logic [7:0] seen, last_byte;
  int err_count = 0;
  int n_checks = 0;
  // Released wire falls to its pull-down
  assign link_data_pin_in = link_data_pin_oe ? link_data_pin_out : hoe ? hd : 1'b0;
  twdfp_port dut_u (.clk(clk), .rstn(rstn), .link_clock_pin(link_clock_pin),
    .link_data_pin_in(link_data_pin_in), .link_data_pin_out(link_data_pin_out),
    .link_data_pin_oe(link_data_pin_oe), .core_halted(core_halted), .pins_borrowed_r(pins_borrowed_r),
    .prog_enabled_r(prog_enabled_r), .fp_byte_r(fp_byte_r), .fp_byte_valid_r(fp_byte_valid_r),
    .fp_byte_is_cmd_r(fp_byte_is_cmd_r), .cmd_blk_read_r(cmd_blk_read_r), .cmd_blk_write_r(cmd_blk_write_r),
    .cmd_page_erase_r(cmd_page_erase_r), .cmd_dev_erase_r(cmd_dev_erase_r), .flash_rd_data(flash_rd_data),
    .flash_rd_valid(flash_rd_valid), .flash_cmd_done(flash_cmd_done));
  twdfp_host host_u (.clk(clk), .dw(link_data_pin_in), .ck(link_clock_pin), .hd(hd), .hoe(hoe));
  always @(posedge clk) begin
    if (fp_byte_valid_r) begin
      seen <= {3'h1, cmd_blk_read_r, cmd_blk_write_r, cmd_page_erase_r, cmd_dev_erase_r, fp_byte_is_cmd_r};
      last_byte <= fp_byte_r;
    end
  end
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task aw(input logic [7:0] v);
    host_u.xfer(1'b1, 1'b1, v, r);
    chk("addr ack", r, 8'h01);
  endtask
  task dw(input logic [7:0] v);
    seen = 8'h00;
    host_u.xfer(1'b1, 1'b0, v, r);
    chk("data ack", r, 8'h01);
  endtask
  task dr(input logic [7:0] e);
    host_u.xfer(1'b0, 1'b0, 8'h00, r);
    chk("data read", r, e);
  endtask
  task ar(input logic [7:0] e);
    host_u.xfer(1'b0, 1'b1, 8'h00, r);
    chk("addr read", r, e);
  endtask
  task t_ids;
    chk("borrowed", pins_borrowed_r, 8'h01);
    ar(8'h00);
    dr(8'h5A);
    dw(8'hFF);
    dr(8'h5A);
    aw(8'h01);
    dr(8'h11);
    aw(8'h55);
    dw(8'h77);
    dr(8'h00);
    ar(8'h55);
    $display("ids done");
  endtask
  task t_unlock;
    aw(8'h02);
    dw(8'h01);
    dw(8'h02);
    chk("locked", prog_enabled_r, 8'h00);
    aw(8'hB4);
    dw(8'h3C);
    chk("no pass", seen, 8'h00);
    dr(8'h3C);
    aw(8'h02);
    dw(8'h02);
    dw(8'h01);
    chk("unlocked", prog_enabled_r, 8'h01);
    dr(8'h01);
    $display("unlock done");
  endtask
  task t_cmds;
    logic [7:0] code [5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h09};
    logic [7:0] exp [5] = '{8'h31, 8'h29, 8'h25, 8'h23, 8'h21};
    aw(8'hB4);
    for (int i = 0; i < 5; i++) begin
      dw(code[i]);
      chk("cmd", seen, exp[i]);
      chk("cmd byte", last_byte, code[i]);
      dw(8'h12);
      chk("operand", seen, i < 4 ? 8'h20 : 8'h21);
      chk("operand byte", last_byte, 8'h12);
      @(negedge clk) flash_cmd_done = 1;
      @(negedge clk) flash_cmd_done = 0;
    end
    @(negedge clk) flash_rd_data = 8'hA5;
    flash_rd_valid = 1;
    @(negedge clk) flash_rd_valid = 0;
    dr(8'hA5);
    $display("cmds done");
  endtask
  task t_halt;
    @(negedge clk) core_halted = 0;
    host_u.xfer(1'b1, 1'b1, 8'h01, r);
    chk("halt ack", r, 8'h00);
    chk("borrowed", pins_borrowed_r, 8'h00);
    core_halted = 1;
    ar(8'hB4);
    chk("sticky", prog_enabled_r, 8'h01);
    rstn = 0;
    repeat (2) @(negedge clk);
    rstn = 1;
    repeat (6) @(negedge clk);
    chk("after reset", prog_enabled_r, 8'h00);
    ar(8'h00);
    $display("halt done");
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2ms;
    err_count++;
    final_report;
  end
  initial begin
    rstn = 0;
    core_halted = 1;
    flash_rd_valid = 0;
    flash_cmd_done = 0;
    flash_rd_data = 8'h00;
    repeat (2) @(negedge clk);
    rstn = 1;
    repeat (6) @(negedge clk);
    t_ids;
    t_unlock;
    t_cmds;
    t_halt;
    final_report;
  end
endmodule
bind twdfp_port twdfp_chk chk_u (.clk(clk), .rstn(rstn), .core_halted(core_halted),
  .link_data_pin_oe(link_data_pin_oe), .prog_enabled_r(prog_enabled_r), .fp_byte_r(fp_byte_r),
  .fp_byte_valid_r(fp_byte_valid_r), .fp_byte_is_cmd_r(fp_byte_is_cmd_r),
  .cmd_blk_read_r(cmd_blk_read_r), .cmd_blk_write_r(cmd_blk_write_r),
  .cmd_page_erase_r(cmd_page_erase_r), .cmd_dev_erase_r(cmd_dev_erase_r));
`default_nettype wire
